/* rtl/dcb_unit.sv */
// Debug command decoder, breakpoint status and debug interrupt control
// Operation
// - Control register read returns 32 bits, upper half first
// - Control register write: selector then data, all 32 bits written
// - Control write answers FFFF, or status bit set with 0001 on error
// - Debug read uses field 4 and selector; only selector 0 valid
// - Config read clears breakpoint state after final level triggered
// - Debug read result is 32 bits, upper half first
// - Debug write takes 32 data bits upper first, answers FFFF
// - Core and link may write; only config register is readable
// - Breakpoint state encoded as listed nibble and field codes
// - Status nibble shown on data outputs when they are idle
// - Writing either trigger register clears breakpoint state
// - PC hits precise before instruction; other hits pend, imprecise
// - Response 01 halts the core with status F
// - Response 10 raises debug interrupt pending to the sample point
// - Taken debug interrupt shows status D and enters emulator mode
// - Vector offset 034 for PC hits, 030 for other triggers
// - Last event picks vector; simultaneous events pick 030
// - Exception saves and clears emulator bit; return restores it
// - Ordinary interrupts still sampled during debug handler
// - Return from the debug handler leaves emulator mode
// - Breakpoints suppressed until first instruction after return
module dcb_unit import dcb_pkg::*; #(
  parameter int PST_D_CYCLES = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Serial debug link
  input  wire logic        debug_serial_clock,
  input  wire logic        ser_din,
  output logic             ser_dout,
  // Control register access toward the core
  output dcb_creg_t        creg,
  input  wire logic        creg_ack,
  input  wire logic        creg_berr,
  input  wire logic [31:0] creg_rdata,
  // Core debug register write
  input  wire logic        core_wr_en,
  input  wire logic [4:0]  core_wr_sel,
  input  wire logic [31:0] core_wr_data,
  // Breakpoint hits and core events
  input  wire dcb_bp_t     bp_hit,
  input  wire logic        sample_point,
  input  wire logic        exc_start,
  input  wire logic        return_from_exception,
  input  wire logic        rte_fs1,
  input  wire logic        instr_done,
  input  wire logic        core_go,
  input  wire logic [3:0]  core_pst,
  input  wire logic        pst_busy,
  input  wire logic [3:0]  core_pdata,
  // Responses to the core and status pins
  output logic             halt_req,
  output logic             dbg_take,
  output logic [11:0]      vec_off,
  output logic             emu_mode,
  output logic             emulator_fault_flag,
  output logic [3:0]       processor_status_code,
  output logic [3:0]       processor_status_data_out
);
  typedef enum logic [1:0] {S_CMD, S_OP, S_BUSY, S_RES_LO} dcb_st_t;
  typedef enum logic [1:0] {K_RDC, K_WRC, K_WRD} dcb_kind_t;

  function automatic logic is_dbg(input logic [15:0] w,
                                  input logic [7:0]  hi);
    is_dbg = (w[15:8] == hi) && (w[7:5] == CMD_DBG_FLD);
  endfunction : is_dbg

  function automatic logic [3:0] nibble(input logic [3:0] bs);
    unique case (bs)
      BS_WAIT1: nibble = NIB_WAIT1;
      BS_HIT1:  nibble = NIB_HIT1;
      BS_WAIT2: nibble = NIB_WAIT2;
      BS_HIT2:  nibble = NIB_HIT2;
      default:  nibble = 4'h0;
    endcase
  endfunction : nibble

  // Link domain
  logic [4:0]  lbit_r;
  logic [15:0] lin_r;
  logic [15:0] word_l_r;
  logic [15:0] lout_r;
  logic        ltog_r;
  logic        rs1_r;
  logic        rs2_r;
  logic        lack_r;
  logic        ser_dout_r;
  // Core domain
  logic        cs1_r;
  logic        cs2_r;
  logic        cs3_r;
  logic        rx;
  dcb_st_t     st_r;
  dcb_kind_t   kind_r;
  logic [1:0]  opn_r;
  logic [63:0] opq_r;
  logic [15:0] res_lo_r;
  logic [16:0] resp_r;
  logic        rtog_r;
  logic        lw_r;
  logic [4:0]  dsel_r;
  logic        rdclr_r;
  dcb_creg_t   creg_r;
  logic        dbg_we;
  logic [4:0]  dbg_sel;
  logic [31:0] dbg_wd;
  logic [27:0] csr_r;
  logic [3:0]  breakpoint_state_field_r;
  logic [31:0] tdr_r;
  logic [31:0] extended_trigger_definition_r;
  logic        l2en;
  logic        hit;
  logic        arm_r;
  logic        fire;
  logic        fire_ad;
  logic        pend_r;
  logic        pend_ad_r;
  logic        take;
  logic        inhib_r;
  logic        emu_r;
  logic        fs1_r;
  logic        halt_r;
  logic        take_r;
  logic [11:0] vec_r;
  logic [7:0]  pstd_r;
  logic        exit_r;
  logic [3:0]  pst_r;
  logic [3:0]  pdat_r;

  // Serial shifter; lead edges let the response toggle settle
  always_ff @(posedge debug_serial_clock or negedge resetn) begin
    if (!resetn) begin
      lbit_r   <= '0;
      lin_r    <= '0;
      word_l_r <= '0;
      ltog_r   <= 1'b0;
    end else begin
      lbit_r <= (lbit_r == FRAME_EDGES - 5'd1) ? '0 : lbit_r + 5'd1;
      if (lbit_r >= LEAD_EDGES)
        lin_r <= {lin_r[14:0], ser_din};
      if (lbit_r == FRAME_EDGES - 5'd1) begin
        word_l_r <= {lin_r[14:0], ser_din};
        ltog_r   <= ~ltog_r;
      end
    end
  end

  always_ff @(posedge debug_serial_clock or negedge resetn) begin
    if (!resetn) begin
      rs1_r      <= 1'b0;
      rs2_r      <= 1'b0;
      lack_r     <= 1'b0;
      ser_dout_r <= 1'b0;
      lout_r     <= '0;
    end else begin
      rs1_r <= rtog_r;
      rs2_r <= rs1_r;
      if (lbit_r == LEAD_EDGES) begin
        lack_r <= rs2_r;
        if (rs2_r != lack_r)
          {ser_dout_r, lout_r} <= resp_r;
        else
          {ser_dout_r, lout_r} <= {1'b0, RESP_NOTRDY};
      end else begin
        {ser_dout_r, lout_r} <= {lout_r, 1'b0};
      end
    end
  end
  assign ser_dout = ser_dout_r;

  // Received word event into the core domain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs1_r <= 1'b0;
      cs2_r <= 1'b0;
      cs3_r <= 1'b0;
    end else begin
      cs1_r <= ltog_r;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
    end
  end
  assign rx = cs2_r ^ cs3_r;

  // Command sequencer; every new response flips rtog_r
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r     <= S_CMD;
      kind_r   <= K_RDC;
      opn_r    <= '0;
      opq_r    <= '0;
      res_lo_r <= '0;
      resp_r   <= '0;
      rtog_r   <= 1'b0;
      lw_r     <= 1'b0;
      dsel_r   <= '0;
      rdclr_r  <= 1'b0;
      creg_r   <= '0;
    end else begin
      lw_r    <= 1'b0;
      rdclr_r <= 1'b0;
      unique case (st_r)
        S_CMD: if (rx) begin
          if (word_l_r == CMD_READ_CTRL) begin
            kind_r <= K_RDC;
            opn_r  <= 2'd1;
            st_r   <= S_OP;
          end else if (word_l_r == CMD_WRITE_CTRL) begin
            kind_r <= K_WRC;
            opn_r  <= 2'd3;
            st_r   <= S_OP;
          end else if (is_dbg(word_l_r, CMD_DBG_WR_HI)) begin
            kind_r <= K_WRD;
            dsel_r <= word_l_r[4:0];
            opn_r  <= 2'd1;
            st_r   <= S_OP;
          end else if (is_dbg(word_l_r, CMD_DBG_RD_HI) &&
                       word_l_r[4:0] == SEL_CONFIG) begin
            resp_r   <= {1'b0, breakpoint_state_field_r, csr_r[27:16]};
            res_lo_r <= csr_r[15:0];
            rtog_r   <= ~rtog_r;
            rdclr_r  <= 1'b1;
            st_r     <= S_RES_LO;
          end else begin
            resp_r <= RESP_ILLEGAL;
            rtog_r <= ~rtog_r;
          end
        end
        S_OP: if (rx) begin
          opq_r <= {opq_r[47:0], word_l_r};
          opn_r <= opn_r - 2'd1;
          if (opn_r == 2'd0) begin
            unique case (kind_r)
              K_RDC: begin
                creg_r.req <= 1'b1;
                creg_r.we  <= 1'b0;
                creg_r.sel <= word_l_r[11:0];
                st_r       <= S_BUSY;
              end
              K_WRC: begin
                creg_r.req   <= 1'b1;
                creg_r.we    <= 1'b1;
                creg_r.sel   <= opq_r[27:16];
                creg_r.wdata <= {opq_r[15:0], word_l_r};
                st_r         <= S_BUSY;
              end
              K_WRD: begin
                lw_r   <= 1'b1;
                resp_r <= {1'b0, RESP_DONE};
                rtog_r <= ~rtog_r;
                st_r   <= S_CMD;
              end
            endcase
          end
        end
        S_BUSY: if (creg_ack) begin
          creg_r.req <= 1'b0;
          rtog_r     <= ~rtog_r;
          if (kind_r == K_RDC) begin
            resp_r   <= {1'b0, creg_rdata[31:16]};
            res_lo_r <= creg_rdata[15:0];
            st_r     <= S_RES_LO;
          end else begin
            resp_r <= creg_berr ? {1'b1, RESP_BERR}
                                : {1'b0, RESP_DONE};
            st_r   <= S_CMD;
          end
        end
        S_RES_LO: if (rx) begin
          resp_r <= {1'b0, res_lo_r};
          rtog_r <= ~rtog_r;
          st_r   <= S_CMD;
        end
      endcase
    end
  end
  assign creg = creg_r;

  // Core instruction writes win; host keeps the link idle meanwhile
  assign dbg_we  = core_wr_en | lw_r;
  assign dbg_sel = core_wr_en ? core_wr_sel : dsel_r;
  assign dbg_wd  = core_wr_en ? core_wr_data : opq_r[31:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csr_r  <= CSR_RESET[27:0];
      tdr_r  <= TRIG_RESET;
      extended_trigger_definition_r <= TRIG_RESET;
    end else if (dbg_we) begin
      if (dbg_sel == SEL_CONFIG)
        csr_r <= dbg_wd[27:0];
      if (dbg_sel == SEL_TRIG)
        tdr_r <= dbg_wd;
      if (dbg_sel == SEL_XTRIG)
        extended_trigger_definition_r <= dbg_wd;
    end
  end

  // Breakpoint state field
  assign l2en    = tdr_r[L2_EN_BIT];
  assign hit     = !inhib_r && (bp_hit.pc || bp_hit.ad);
  assign fire    = hit && ((breakpoint_state_field_r == BS_WAIT2) ||
                   (breakpoint_state_field_r == BS_WAIT1 && !l2en));
  assign fire_ad = bp_hit.ad;

  // Arming only on a definition write, so cleared state stays clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      arm_r <= 1'b0;
    else
      arm_r <= dbg_we && dbg_sel == SEL_TRIG && dbg_wd[L1_EN_BIT];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      breakpoint_state_field_r <= BS_NONE;
    end else if (dbg_we && (dbg_sel == SEL_TRIG ||
                            dbg_sel == SEL_XTRIG)) begin
      breakpoint_state_field_r <= BS_NONE;
    end else if (dbg_we && dbg_sel == SEL_CONFIG) begin
      breakpoint_state_field_r <= dbg_wd[BREAKPOINT_STATE_FIELD_LSB +: 4];
    end else if (rdclr_r && (breakpoint_state_field_r == BS_HIT2 ||
                 (breakpoint_state_field_r == BS_HIT1 && !l2en))) begin
      breakpoint_state_field_r <= BS_NONE;
    end else if (arm_r) begin
      breakpoint_state_field_r <= BS_WAIT1;
    end else if (hit && breakpoint_state_field_r == BS_WAIT1) begin
      breakpoint_state_field_r <= l2en ? BS_WAIT2 : BS_HIT1;
    end else if (hit && breakpoint_state_field_r == BS_WAIT2) begin
      breakpoint_state_field_r <= BS_HIT2;
    end
  end

  // PC hits are taken at their own sample point, others pend
  assign take = sample_point && !emu_r &&
                (pend_r || (fire && bp_hit.pc &&
                 tdr_r[TRC_LSB +: 2] == TRC_IRQ));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r    <= 1'b0;
      pend_ad_r <= 1'b0;
    end else if (fire && tdr_r[TRC_LSB +: 2] == TRC_IRQ &&
                 !take) begin
      pend_r    <= 1'b1;
      pend_ad_r <= fire_ad;
    end else if (take) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      halt_r <= 1'b0;
    else if (fire && tdr_r[TRC_LSB +: 2] == TRC_HALT)
      halt_r <= 1'b1;
    else if (core_go)
      halt_r <= 1'b0;
  end

  // Emulator mode, saved bit and post-return inhibit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      emu_r   <= 1'b0;
      fs1_r   <= 1'b0;
      inhib_r <= 1'b0;
      take_r  <= 1'b0;
      vec_r   <= '0;
      pstd_r  <= '0;
      exit_r  <= 1'b0;
    end else begin
      take_r <= take;
      exit_r <= 1'b0;
      if (pstd_r != 8'd0)
        pstd_r <= pstd_r - 8'd1;
      if (instr_done)
        inhib_r <= 1'b0;
      if (take) begin
        emu_r  <= 1'b1;
        pstd_r <= 8'(PST_D_CYCLES);
        vec_r  <= (pend_r ? pend_ad_r : fire_ad) ?
                  VEC_OFF_OTHER : VEC_OFF_PC;
      end else if (exc_start) begin
        fs1_r <= emu_r;
        emu_r <= 1'b0;
      end else if (return_from_exception) begin
        if (rte_fs1) begin
          emu_r  <= 1'b1;
          pstd_r <= 8'(PST_D_CYCLES);
        end else if (emu_r) begin
          emu_r   <= 1'b0;
          exit_r  <= 1'b1;
          inhib_r <= 1'b1;
        end
      end
    end
  end

  // Status pins; normal interrupts are never masked here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pst_r  <= '0;
      pdat_r <= '0;
    end else begin
      if (pstd_r != 8'd0 || take)
        pst_r <= PST_DBG;
      else if (halt_r)
        pst_r <= PST_HALT;
      else if (exit_r)
        pst_r <= PST_EXIT;
      else
        pst_r <= core_pst;
      pdat_r <= pst_busy ? core_pdata : nibble(breakpoint_state_field_r);
    end
  end

  assign halt_req                  = halt_r;
  assign dbg_take                  = take_r;
  assign vec_off                   = vec_r;
  assign emu_mode                  = emu_r;
  assign emulator_fault_flag       = fs1_r;
  assign processor_status_code     = pst_r;
  assign processor_status_data_out = pdat_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_done;
    st_r == S_BUSY && kind_r == K_WRC && creg_ack;
  endsequence

  a_ctrl_write_resp: assert property (s_wr_done |=>
    resp_r == ($past(creg_berr) ? {1'b1, RESP_BERR} : {1'b0, RESP_DONE}))
    else $error("control write answer wrong");
  a_csr_read_hi: assert property (
    st_r == S_CMD && rx && is_dbg(word_l_r, CMD_DBG_RD_HI) &&
    word_l_r[4:0] == SEL_CONFIG |=> resp_r[15:12] == $past(breakpoint_state_field_r) &&
    st_r == S_RES_LO) else $error("config read high half wrong");
  a_reserved_sel: assert property (
    st_r == S_CMD && rx && is_dbg(word_l_r, CMD_DBG_RD_HI) &&
    word_l_r[4:0] != SEL_CONFIG |=> resp_r == RESP_ILLEGAL &&
    $stable(csr_r) && st_r == S_CMD) else $error("reserved read accepted");
  a_trig_clear: assert property (
    dbg_we && dbg_sel == SEL_TRIG |=> breakpoint_state_field_r == BS_NONE)
    else $error("trigger write kept state");
  a_read_clear: assert property (
    rdclr_r && !dbg_we && (breakpoint_state_field_r == BS_HIT2 ||
    (breakpoint_state_field_r == BS_HIT1 && !l2en)) |=> breakpoint_state_field_r == BS_NONE)
    else $error("config read did not clear state");
  a_halt_status: assert property (
    fire && tdr_r[TRC_LSB +: 2] == TRC_HALT && !core_go
    |=> halt_r ##1 pst_r == PST_HALT) else $error("halt status missing");

  sequence s_entry;
    emu_r && pst_r == PST_DBG;
  endsequence

  a_dbg_entry: assert property (take |=> s_entry [*2])
    else $error("debug entry status missing");
  a_vector_off: assert property (
    take_r |-> vec_off == VEC_OFF_OTHER || vec_off == VEC_OFF_PC)
    else $error("bad vector offset");
  a_inhibit_hit: assert property (inhib_r |-> !fire)
    else $error("breakpoint after return");
  a_rte_exit: assert property (
    return_from_exception && emu_r && !rte_fs1 && !take && !exc_start
    |=> !emu_r && inhib_r ##1 pst_r == PST_EXIT || pst_r == PST_DBG)
    else $error("return did not leave emulator mode");
endmodule : dcb_unit

/* shared/dcb_pkg.sv */
// Shared constants and types for the debug command and breakpoint unit
package dcb_pkg;
  // Serial command words
  localparam logic [15:0] CMD_READ_CTRL  = 16'h2980;
  localparam logic [15:0] CMD_WRITE_CTRL = 16'h2880;
  localparam logic [7:0]  CMD_DBG_RD_HI  = 8'h2D;
  localparam logic [7:0]  CMD_DBG_WR_HI  = 8'h2C;
  localparam logic [2:0]  CMD_DBG_FLD    = 3'h4;
  // Response words, bit 16 is the status bit
  localparam logic [15:0] RESP_DONE      = 16'hFFFF;
  localparam logic [15:0] RESP_BERR      = 16'h0001;
  localparam logic [15:0] RESP_NOTRDY    = 16'h0000;
  localparam logic [16:0] RESP_ILLEGAL   = 17'h1_FFFF;
  // Serial framing: lead edges for the crossing, then 17 data edges
  localparam logic [4:0]  LEAD_EDGES     = 5'd2;
  localparam logic [4:0]  FRAME_EDGES    = 5'd19;
  // Debug register selectors
  localparam logic [4:0]  SEL_CONFIG     = 5'h00;
  localparam logic [4:0]  SEL_XTRIG      = 5'h06;
  localparam logic [4:0]  SEL_TRIG       = 5'h07;
  localparam logic [31:0] CSR_RESET      = 32'h0000_0000;
  localparam logic [31:0] TRIG_RESET     = 32'h0000_0000;
  // Field positions
  localparam int          BREAKPOINT_STATE_FIELD_LSB      = 28;
  localparam int          TRC_LSB        = 30;
  localparam int          L2_EN_BIT      = 29;
  localparam int          L1_EN_BIT      = 13;
  // Breakpoint state field codes and status nibbles
  localparam logic [3:0]  BS_NONE        = 4'h0;
  localparam logic [3:0]  BS_WAIT1       = 4'h1;
  localparam logic [3:0]  BS_HIT1        = 4'h2;
  localparam logic [3:0]  BS_WAIT2       = 4'h5;
  localparam logic [3:0]  BS_HIT2        = 4'h6;
  localparam logic [3:0]  NIB_WAIT1      = 4'h2;
  localparam logic [3:0]  NIB_HIT1       = 4'h4;
  localparam logic [3:0]  NIB_WAIT2      = 4'hA;
  localparam logic [3:0]  NIB_HIT2       = 4'hC;
  // Trigger responses and status codes
  localparam logic [1:0]  TRC_HALT       = 2'b01;
  localparam logic [1:0]  TRC_IRQ        = 2'b10;
  localparam logic [3:0]  PST_HALT       = 4'hF;
  localparam logic [3:0]  PST_DBG        = 4'hD;
  localparam logic [3:0]  PST_EXIT       = 4'h7;
  // Debug exception vector offsets
  localparam logic [11:0] VEC_OFF_OTHER  = 12'h030;
  localparam logic [11:0] VEC_OFF_PC     = 12'h034;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] sel;
    logic [31:0] wdata;
  } dcb_creg_t;

  typedef struct packed {
    logic pc;
    logic ad;
  } dcb_bp_t;
endpackage : dcb_pkg

/* sim/dcb_host_model.sv */
// Host-side serial debug link model driving framed words
module dcb_host_model (
  // Link pins
  output logic      debug_serial_clock,
  output logic      ser_din,
  input  wire logic ser_dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    debug_serial_clock = 1'b0;
    ser_din            = 1'b0;
  end

  // One frame: two lead edges, then 17 bits MSB first
  task automatic frame(input logic [15:0] w, output logic [16:0] r);
    logic [16:0] b;
    b = {1'b0, w};
    r = '0;
    #1.3;
    for (int k = 0; k < 19; k++) begin
      if (k > 1) ser_din = b[18-k];
      #16 debug_serial_clock = 1'b1;
      #16 debug_serial_clock = 1'b0;
      if (k > 1) r[18-k] = ser_dout;
    end
    // Released line shows no stale bit
    ser_din = ~ser_din;
  endtask : frame
endmodule : dcb_host_model

/* sim/debug_cmd_breakpoint_unit_bench.sv */
// Self-checking bench for the debug command and breakpoint unit
module debug_cmd_breakpoint_unit_bench
  import dcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] P_SP   = 7'h01;
  localparam logic [6:0] P_AD   = 7'h02;
  localparam logic [6:0] P_PC   = 7'h04;
  localparam logic [6:0] P_EXC  = 7'h08;
  localparam logic [6:0] P_RTE  = 7'h10;
  localparam logic [6:0] P_DONE = 7'h20;
  localparam logic [6:0] P_GO   = 7'h40;

  logic        clk, resetn, debug_serial_clock, ser_din, ser_dout;
  logic        creg_ack, creg_berr, core_wr_en, sample_point, exc_start;
  logic        return_from_exception, rte_fs1, instr_done, core_go;
  logic        pst_busy, halt_req, dbg_take, emu_mode, emulator_fault_flag;
  logic        exp_we, berr_cfg, pend_v;
  logic [3:0]  core_pst, core_pdata, processor_status_code;
  logic [3:0]  processor_status_data_out;
  logic [4:0]  core_wr_sel;
  logic [6:0]  pv;
  logic [11:0] vec_off, exp_sel;
  logic [16:0] pend;
  logic [31:0] creg_rdata, core_wr_data, exp_wd, rd_cfg;
  dcb_creg_t   creg;
  dcb_bp_t     bp_hit;
  int          num_errors, total_checks;

  assign {core_go, instr_done, return_from_exception, exc_start, bp_hit,
          sample_point} = pv;

  dcb_unit #(.PST_D_CYCLES(4)) dut_u (
    .clk, .resetn, .debug_serial_clock, .ser_din, .ser_dout, .creg,
    .creg_ack, .creg_berr, .creg_rdata, .core_wr_en, .core_wr_sel,
    .core_wr_data, .bp_hit, .sample_point, .exc_start,
    .return_from_exception, .rte_fs1, .instr_done, .core_go, .core_pst,
    .pst_busy, .core_pdata, .halt_req, .dbg_take, .vec_off, .emu_mode,
    .emulator_fault_flag, .processor_status_code,
    .processor_status_data_out);
  dcb_host_model host_u (.debug_serial_clock, .ser_din, .ser_dout);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic nib(input logic [3:0] e);
    chk(32'(processor_status_data_out), 32'(e), "nibble");
  endtask : nib

  // One frame; the answer arrives one frame later
  task automatic xfer(input logic [15:0] w, input logic [16:0] nxt,
                      input logic nv);
    logic [16:0] r;
    host_u.frame(w, r);
    if (pend_v) chk(32'(r), 32'(pend), "link answer");
    pend   = nxt;
    pend_v = nv;
    repeat (10 + $urandom_range(0, 6)) @(negedge clk);
  endtask : xfer

  task automatic dbg_wr(input logic [4:0] s, input logic [31:0] d);
    xfer({CMD_DBG_WR_HI, CMD_DBG_FLD, s}, '0, 1'b0);
    xfer(d[31:16], '0, 1'b0);
    xfer(d[15:0], {1'b0, RESP_DONE}, 1'b1);
  endtask : dbg_wr

  task automatic dbg_rd(input logic [31:0] e);
    xfer({CMD_DBG_RD_HI, CMD_DBG_FLD, SEL_CONFIG}, {1'b0, e[31:16]}, 1'b1);
    xfer(16'($urandom), {1'b0, e[15:0]}, 1'b1);
  endtask : dbg_rd

  task automatic ctrl(input logic we, input logic [11:0] s,
                      input logic [31:0] d, input logic be);
    exp_we   = we;
    exp_sel  = s;
    exp_wd   = d;
    rd_cfg   = d;
    berr_cfg = be;
    xfer(we ? CMD_WRITE_CTRL : CMD_READ_CTRL, '0, 1'b0);
    xfer(16'h0000, '0, 1'b0);
    if (we) begin
      xfer({4'h0, s}, '0, 1'b0);
      xfer(d[31:16], '0, 1'b0);
      xfer(d[15:0], be ? {1'b1, RESP_BERR} : {1'b0, RESP_DONE}, 1'b1);
    end else begin
      xfer({4'h0, s}, {1'b0, d[31:16]}, 1'b1);
      xfer(16'($urandom), {1'b0, d[15:0]}, 1'b1);
    end
  endtask : ctrl

  task automatic pulse(input logic [6:0] v);
    @(negedge clk);
    pv = v;
    @(negedge clk);
    pv = '0;
  endtask : pulse

  task automatic core_wr(input logic [31:0] d);
    @(negedge clk);
    core_wr_sel  = SEL_TRIG;
    core_wr_data = d;
    core_wr_en   = 1'b1;
    @(negedge clk);
    core_wr_en   = 1'b0;
    core_wr_data = ~d;
    repeat (2) @(negedge clk);
  endtask : core_wr

  task automatic take(input logic [11:0] v);
    int n;
    n = 0;
    while (dbg_take !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(32'(dbg_take), 32'h0000_0001, "take");
    chk(32'(vec_off), 32'(v), "vector");
  endtask : take

  // Core side of the control register access
  always @(negedge clk) begin
    if (creg.req === 1'b1 && creg_ack === 1'b0) begin
      chk(32'(creg.we), 32'(exp_we), "ctrl dir");
      chk(32'(creg.sel), 32'(exp_sel), "ctrl sel");
      if (exp_we) chk(creg.wdata, exp_wd, "ctrl data");
      creg_ack   <= 1'b1;
      creg_berr  <= berr_cfg;
      creg_rdata <= rd_cfg;
    end else begin
      creg_ack   <= 1'b0;
      creg_berr  <= ~creg_berr;
      creg_rdata <= ~creg_rdata;
    end
  end

  initial begin
    #200_000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    resetn       = 1'b0;
    pv           = '0;
    rte_fs1      = 1'b0;
    core_wr_en   = 1'b0;
    core_wr_sel  = '0;
    core_wr_data = '0;
    core_pst     = 4'h0;
    core_pdata   = 4'h0;
    pst_busy     = 1'b0;
    creg_ack     = 1'b0;
    creg_berr    = 1'b0;
    creg_rdata   = '0;
    num_errors   = 0;
    total_checks = 0;
    pend_v       = 1'b0;
    void'($urandom(32'h2317_9500));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    nib(NIB_WAIT1 & 4'h0);
    dbg_rd(CSR_RESET);
    for (int i = 0; i < 4; i++) begin
      xfer({CMD_DBG_RD_HI, CMD_DBG_FLD, 5'(1 + $urandom_range(0, 30))},
           RESP_ILLEGAL, 1'b1);
    end
    dbg_rd(CSR_RESET);
    for (int i = 0; i < 6; i++) begin
      ctrl(i[0], 12'($urandom), $urandom, i == 5);
    end
    // Single level, halt response
    dbg_wr(SEL_TRIG, {TRC_HALT, 30'h0000_2000});
    nib(NIB_WAIT1);
    dbg_rd({BS_WAIT1, 28'h000_0000});
    pulse(P_AD);
    repeat (3) @(negedge clk);
    chk(32'(halt_req), 32'h0000_0001, "halt");
    chk(32'(processor_status_code), 32'(PST_HALT), "halt code");
    nib(NIB_HIT1);
    core_pdata = 4'($urandom);
    pst_busy   = 1'b1;
    repeat (2) @(negedge clk);
    nib(core_pdata);
    pst_busy = 1'b0;
    dbg_rd({BS_HIT1, 28'h000_0000});
    dbg_rd(CSR_RESET);
    pulse(P_GO);
    repeat (2) @(negedge clk);
    chk(32'(halt_req), 32'h0000_0000, "resume");
    // Two levels, debug interrupt, written by the core
    core_wr({TRC_IRQ, 30'h2000_2000});
    nib(NIB_WAIT1);
    pulse(P_PC);
    repeat (2) @(negedge clk);
    nib(NIB_WAIT2);
    pulse(P_AD);
    repeat (4) @(negedge clk);
    chk(32'(dbg_take), 32'h0000_0000, "pending");
    nib(NIB_HIT2);
    pulse(P_SP);
    take(VEC_OFF_OTHER);
    @(negedge clk);
    chk(32'(processor_status_code), 32'(PST_DBG), "dbg code");
    chk(32'(emu_mode), 32'h0000_0001, "emu");
    pulse(P_EXC);
    repeat (2) @(negedge clk);
    chk(32'(emu_mode), 32'h0000_0000, "exc");
    chk(32'(emulator_fault_flag), 32'h0000_0001, "saved");
    rte_fs1 = 1'b1;
    pulse(P_RTE);
    repeat (2) @(negedge clk);
    chk(32'(emu_mode), 32'h0000_0001, "restore");
    chk(32'(processor_status_code), 32'(PST_DBG), "reenter");
    dbg_wr(SEL_XTRIG, $urandom);
    nib(4'h0);
    dbg_rd(CSR_RESET);
    // Inhibit after return, then a precise program counter hit
    core_wr({TRC_IRQ, 30'h0000_2000});
    rte_fs1 = 1'b0;
    pulse(P_RTE);
    pulse(P_PC | P_SP);
    repeat (4) @(negedge clk);
    chk(32'(dbg_take), 32'h0000_0000, "inhibit");
    chk(32'(emu_mode), 32'h0000_0000, "exit");
    pulse(P_DONE);
    pulse(P_PC | P_SP);
    take(VEC_OFF_PC);
    xfer(16'h0000, '0, 1'b0);
    report_and_stop();
  end
endmodule : debug_cmd_breakpoint_unit_bench
